// >>> core/cmp_defines.svh
// Register offsets, field positions, reset values and timing counts for the comparator control
`ifndef CMP_DEFINES_SVH
`define CMP_DEFINES_SVH

`define ADDR_CONTROL        4'h0
`define ADDR_DAC            4'h2
`define ADDR_STATUS         4'h4
`define ADDR_MASK           4'h6

`define CTRL_ENABLE_BIT     15
`define CTRL_IDLE_BIT       13
`define CTRL_SEL_HI         7
`define CTRL_SEL_LO         6
`define CTRL_EXTERNAL_DAC_REFERENCE_BIT     5
`define CTRL_STATE_BIT      3
`define CTRL_POL_BIT        1
`define CTRL_RANGE_BIT      0

`define CTRL_RESET          16'h0000
`define DAC_RESET           10'h000
`define DAC_WIDTH           10

`define EVT_RISE_BIT        0
`define EVT_FALL_BIT        1
`define EVT_WIDTH           2

`define CLK_PERIOD_PS       5000
`define FILTER_TIME_PS      66000
`define FILTER_CYCLES       ((`FILTER_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// >>> core/cmp_pkg.sv
// Types shared by the comparator control logic
package cmp_pkg;
    typedef enum logic [1:0] {
        RANGE_HALF_SUPPLY,
        RANGE_INTERNAL,
        RANGE_EXTERNAL
    } dac_range_t;

    typedef enum logic [1:0] {
        POWER_RUN,
        POWER_IDLE,
        POWER_SLEEP
    } power_mode_t;
endpackage

// >>> core/analog_comparator_control.sv
// Digital control and output routing for one fast analog comparator
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "cmp_defines.svh"
// How it works
// - Polarity select inverts or passes comparator result
// - Active edge of result can raise interrupt
// - Active result pulse triggers ADC conversion
// - Active result ends PWM pulse early
// - Active result cuts PWM period short
// - Active result latches fault, disabling PWM
// - One filtered result feeds all enabled consumers but wake together
// - Raw result wakes system from Sleep/Idle
// - Inverting input fixed to DAC output
// - Source selection drives positive-input mux lines
// - Software 10-bit code drives reference DAC
// - Range mux: half supply, 1.2V, external
// - Disabled module powers down comparator, DAC
// - Two-bit select picks one of four pins
// - Filter hides short pulses; bypass when asleep
// - One-cycle pulse for ADC and interrupt
// - Any group halt-in-idle disables all in Idle
module analog_comparator_control
    import cmp_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic [3:0]                reg_addr,
    input  wire logic [15:0]               reg_wdata,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    output logic      [15:0]               reg_rdata,
    output logic                           irq,
    input  wire logic                      comparator_raw,
    input  wire cmp_pkg::power_mode_t      power_mode,
    input  wire logic                      group_halt_during_idle,
    output logic                           halt_during_idle,
    output logic      [3:0]                source_pin_select,
    output logic                           dac_negative_input_select,
    output logic      [`DAC_WIDTH-1:0]     dac_code,
    output cmp_pkg::dac_range_t            dac_range,
    output logic                           external_dac_reference,
    output logic                           internal_dac_reference,
    output logic                           analog_power_enable,
    output logic                           comparator_result,
    output logic                           adc_trigger,
    output logic                           pwm_duty_limit,
    output logic                           pwm_period_truncate,
    output logic                           pwm_fault,
    input  wire logic                      pwm_fault_clear,
    output logic                           wake_request
);
    import cmp_pkg::*;

    // ****************************************
    // Configuration registers
    // ****************************************
    logic                  enable;
    logic                  output_inversion;
    logic [1:0]            sel_code;
    logic                  ext_ref;
    logic                  range_high;
    logic                  idle_halt;
    logic [`DAC_WIDTH-1:0] dac_value;
    logic [`EVT_WIDTH-1:0] status;
    logic [`EVT_WIDTH-1:0] mask;

    // ****************************************
    // Decoding helpers
    // ****************************************
    function automatic logic [3:0] decode_select(input logic [1:0] code);
        decode_select = 4'h1 << code;
    endfunction

    function automatic logic hit(input logic [3:0] addr, input logic [3:0] target);
        hit = (addr == target);
    endfunction

    // Idle halt from any comparator of the group stops all of them
    function automatic logic idle_halted(input power_mode_t mode, input logic own_halt,
                                         input logic group_halt);
        idle_halted = (mode == POWER_IDLE) && (own_halt || group_halt);
    endfunction

    // ****************************************
    // Register write decode
    // ****************************************
    logic write_control;
    logic write_dac;
    logic write_status;
    logic write_mask;

    // Strobes are one cycle long, so each decode is a one-cycle pulse too
    assign write_control = reg_write && hit(reg_addr, `ADDR_CONTROL);
    assign write_dac     = reg_write && hit(reg_addr, `ADDR_DAC);
    assign write_status  = reg_write && hit(reg_addr, `ADDR_STATUS);
    assign write_mask    = reg_write && hit(reg_addr, `ADDR_MASK);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enable           <= 1'b0;
            output_inversion <= 1'b0;
            sel_code         <= 2'h0;
            ext_ref          <= 1'b0;
            range_high       <= 1'b0;
            idle_halt        <= 1'b0;
        end else if (write_control) begin
            // Read-only and reserved bits are not stored
            enable           <= reg_wdata[`CTRL_ENABLE_BIT];
            idle_halt        <= reg_wdata[`CTRL_IDLE_BIT];
            sel_code         <= reg_wdata[`CTRL_SEL_HI:`CTRL_SEL_LO];
            ext_ref          <= reg_wdata[`CTRL_EXTERNAL_DAC_REFERENCE_BIT];
            output_inversion <= reg_wdata[`CTRL_POL_BIT];
            range_high       <= reg_wdata[`CTRL_RANGE_BIT];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dac_value <= `DAC_RESET;
        end else if (write_dac) begin
            // Upper data bits are reserved and dropped
            dac_value <= reg_wdata[`DAC_WIDTH-1:0];
        end
    end

    // ****************************************
    // Analog steering
    // ****************************************
    logic       active;
    logic [3:0] decoded_select;

    assign active = enable &&
                    !idle_halted(power_mode, idle_halt, group_halt_during_idle);

    assign halt_during_idle          = idle_halt;
    assign analog_power_enable       = active;
    assign dac_negative_input_select = 1'b1;
    assign decoded_select            = decode_select(sel_code);
    assign dac_code                  = dac_value;
    assign external_dac_reference    = ext_ref;
    assign internal_dac_reference    = !ext_ref && !range_high;

    // Select lines drop while the module is off, freeing the pads
    generate
        for (genvar p = 0; p < 4; p++) begin : g_source
            assign source_pin_select[p] = active && decoded_select[p];
        end
    endgenerate

    // ****************************************
    // Reference range
    // ****************************************
    // External reference overrides the range bit
    always_comb begin
        if (ext_ref) begin
            dac_range = RANGE_EXTERNAL;
        end else if (range_high) begin
            dac_range = RANGE_HALF_SUPPLY;
        end else begin
            dac_range = RANGE_INTERNAL;
        end
    end

    // ****************************************
    // Synchroniser and glitch filter
    // ****************************************
    logic       sync_first;
    logic       sync_second;
    logic       polar;
    logic [3:0] stable_count;
    logic       filtered;
    logic       filtered_prev;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_first  <= 1'b0;
            sync_second <= 1'b0;
        end else begin
            // Only the second stage feeds logic; the first may be metastable
            sync_first  <= comparator_raw;
            sync_second <= sync_first;
        end
    end

    // An inactive module reports no result, whatever the pin does
    assign polar = active && (sync_second ^ output_inversion);

    // ****************************************
    // Glitch filter
    // ****************************************
    // Count is fixed for this clock rate; another clock needs new timing values
    localparam logic [3:0] FILTER_LAST = 4'(`FILTER_CYCLES - 1);

    // Level must hold the full filter time before it is believed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stable_count <= 4'h0;
            filtered     <= 1'b0;
        end else if (polar == filtered) begin
            stable_count <= 4'h0;
        end else if (stable_count == FILTER_LAST) begin
            stable_count <= 4'h0;
            filtered     <= polar;
        end else begin
            stable_count <= stable_count + 4'h1;
        end
    end

    // ****************************************
    // Edge detection
    // ****************************************
    // Previous filtered level, for the one-cycle pulses
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            filtered_prev <= 1'b0;
        end else begin
            filtered_prev <= filtered;
        end
    end

    // ****************************************
    // Consumers
    // ****************************************
    logic rise_pulse;
    logic fall_pulse;
    logic asleep;

    assign rise_pulse = filtered && !filtered_prev;
    assign fall_pulse = !filtered && filtered_prev;
    assign asleep     = (power_mode != POWER_RUN);

    // All consumers but the wake path see the same filtered level in the same cycle
    assign comparator_result   = filtered;
    assign pwm_duty_limit      = filtered;
    assign pwm_period_truncate = filtered;
    assign adc_trigger         = rise_pulse;

    // Clock may be gated when asleep, so this path skips synchroniser and filter
    assign wake_request = asleep && enable &&
                          !idle_halted(power_mode, idle_halt, group_halt_during_idle) &&
                          (comparator_raw ^ output_inversion);

    // ****************************************
    // PWM fault latch
    // ****************************************
    // A live fault wins over the clear, so the outputs stay safe

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_fault <= 1'b0;
        end else if (filtered) begin
            pwm_fault <= 1'b1;
        end else if (pwm_fault_clear) begin
            pwm_fault <= 1'b0;
        end
    end

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    logic [`EVT_WIDTH-1:0] events;
    // Bit zero marks a rise of the result, bit one a fall
    assign events = {fall_pulse, rise_pulse};

    logic [`EVT_WIDTH-1:0] clear_request;
    assign clear_request = write_status ? reg_wdata[`EVT_WIDTH-1:0] : '0;

    // A new event wins over a write-one clear in the same cycle
    generate
        for (genvar e = 0; e < `EVT_WIDTH; e++) begin : g_status
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    status[e] <= 1'b0;
                end else if (events[e]) begin
                    status[e] <= 1'b1;
                end else if (clear_request[e]) begin
                    status[e] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mask <= '0;
        end else if (write_mask) begin
            // Mask bits line up with the status bits
            mask <= reg_wdata[`EVT_WIDTH-1:0];
        end
    end

    // ****************************************
    // Interrupt output
    // ****************************************
    // Wake path is included so an unclocked core still sees the request
    assign irq = |(status & mask) || wake_request;

    // ****************************************
    // Read port
    // ****************************************
    logic [15:0] control_word;
    logic [15:0] next_rdata;

    // Read-only state bit shows the filtered, polarity-adjusted result
    always_comb begin
        control_word                            = 16'h0000;
        control_word[`CTRL_ENABLE_BIT]          = enable;
        control_word[`CTRL_IDLE_BIT]            = idle_halt;
        control_word[`CTRL_SEL_HI:`CTRL_SEL_LO] = sel_code;
        control_word[`CTRL_EXTERNAL_DAC_REFERENCE_BIT]          = ext_ref;
        control_word[`CTRL_STATE_BIT]           = filtered;
        control_word[`CTRL_POL_BIT]             = output_inversion;
        control_word[`CTRL_RANGE_BIT]           = range_high;
    end

    // Unmapped offsets read zero; the port idles at zero between reads
    always_comb begin
        next_rdata = 16'h0000;
        if (reg_read) begin
            case (reg_addr)
                `ADDR_CONTROL: begin
                    next_rdata = control_word;
                end
                `ADDR_DAC: begin
                    next_rdata = {6'h00, dac_value};
                end
                `ADDR_STATUS: begin
                    next_rdata = {14'h0000, status};
                end
                `ADDR_MASK: begin
                    next_rdata = {14'h0000, mask};
                end
                default: begin
                    next_rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end
endmodule

// >>> tb/cmp_front_end.sv
// Behavioural comparator front end: input mux, threshold compare, output
`timescale 1ns/1ps
module cmp_front_end (
    input  wire logic       clk,
    input  wire logic [9:0] pin_level [4],
    input  wire logic [3:0] source_pin_select,
    input  wire logic [9:0] dac_code,
    input  wire logic       analog_power_enable,
    output logic            comparator_raw
);
    logic       above;
    always_comb begin
        above = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (source_pin_select[i] && pin_level[i] > dac_code) begin
                above = 1'b1;
            end
        end
    end
    // Unpowered comparator output is meaningless, so it toggles every cycle
    always @(posedge clk) begin
        if (analog_power_enable && source_pin_select != 4'h0) begin
            comparator_raw <= above;
        end else begin
            comparator_raw <= ~comparator_raw;
        end
    end
    initial comparator_raw = 1'b0;
endmodule

// >>> tb/analog_comparator_control_assertions.sv
// Port-level checker for the comparator control block
`timescale 1ns/1ps
module comparator_checker
    import cmp_pkg::*;
(
    input wire logic                clk,
    input wire logic                reset_n,
    input wire logic [3:0]          source_pin_select,
    input wire logic                analog_power_enable,
    input wire logic                dac_negative_input_select,
    input wire cmp_pkg::dac_range_t dac_range,
    input wire logic                external_dac_reference,
    input wire logic                comparator_result,
    input wire logic                adc_trigger,
    input wire logic                pwm_duty_limit,
    input wire logic                pwm_period_truncate,
    input wire logic                pwm_fault,
    input wire logic                wake_request,
    input wire logic                irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence trig_pulse;
        adc_trigger ##1 !adc_trigger;
    endsequence
    chk_neg_input_fixed: assert property (dac_negative_input_select)
        else $error("negative input not tied to reference");
    chk_duty_limit_follows: assert property (pwm_duty_limit == comparator_result)
        else $error("duty limit differs from result");
    chk_period_cut_follows: assert property (pwm_period_truncate == comparator_result)
        else $error("period truncate differs from result");
    chk_trigger_one_cycle: assert property (adc_trigger |-> trig_pulse)
        else $error("trigger pulse longer than one cycle");
    chk_trigger_on_rise: assert property ($rose(comparator_result) |-> ##[0:1] trig_pulse)
        else $error("no trigger on result rise");
    chk_fault_latches: assert property (comparator_result |-> ##[0:1] pwm_fault)
        else $error("fault not latched");
    chk_select_one_hot: assert property ($onehot0(source_pin_select))
        else $error("more than one source selected");
    chk_off_no_pin: assert property (!analog_power_enable |-> !(|source_pin_select))
        else $error("source selected while module is off");
    chk_range_external: assert property (external_dac_reference |-> dac_range == RANGE_EXTERNAL)
        else $error("external reference not reflected in range");
    chk_wake_raises_irq: assert property (wake_request |-> irq)
        else $error("wake request without interrupt");
endmodule
bind analog_comparator_control comparator_checker u_comparator_checker (
    .clk(clk), .reset_n(reset_n), .source_pin_select(source_pin_select),
    .analog_power_enable(analog_power_enable),
    .dac_negative_input_select(dac_negative_input_select), .dac_range(dac_range),
    .external_dac_reference(external_dac_reference), .comparator_result(comparator_result),
    .adc_trigger(adc_trigger), .pwm_duty_limit(pwm_duty_limit),
    .pwm_period_truncate(pwm_period_truncate), .pwm_fault(pwm_fault),
    .wake_request(wake_request), .irq(irq));

// >>> tb/test_analog_comparator_control.sv
// Register-driven testbench for the comparator control block
`timescale 1ns/1ps
module test_analog_comparator_control;
    import cmp_pkg::*;
    logic clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, group_halt = 0, fault_clear = 0;
    logic [3:0] reg_addr = 4'h0, sel;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [9:0] pin_level [4] = '{default: 10'h000};
    logic [9:0] dac_code;
    power_mode_t power_mode = POWER_RUN;
    dac_range_t dac_range;
    logic irq, raw, neg_sel, ext_ref, pwr, result, trig, duty, period, fault, wake;
    logic halt_out, int_ref;
    int bad_count = 0, check_count = 0, trig_n = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (trig === 1'b1) trig_n++;
    analog_comparator_control u_analog_comparator_control (.clk(clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .irq(irq), .comparator_raw(raw), .power_mode(power_mode),
        .group_halt_during_idle(group_halt), .halt_during_idle(halt_out),
        .source_pin_select(sel), .dac_negative_input_select(neg_sel), .dac_code(dac_code),
        .dac_range(dac_range), .external_dac_reference(ext_ref),
        .internal_dac_reference(int_ref), .analog_power_enable(pwr),
        .comparator_result(result), .adc_trigger(trig), .pwm_duty_limit(duty),
        .pwm_period_truncate(period), .pwm_fault(fault), .pwm_fault_clear(fault_clear),
        .wake_request(wake));
    cmp_front_end u_cmp_front_end (.clk(clk), .pin_level(pin_level), .source_pin_select(sel),
        .dac_code(dac_code), .analog_power_enable(pwr), .comparator_raw(raw));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a; reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        rd(4'h0, 16'h0000);
        rd(4'h2, 16'h0000);
        chk(16'(dac_range), 16'(RANGE_INTERNAL));
        chk(pwr, 0);
        chk(int_ref, 16'h0001);
        wr(4'h6, 16'h0001);
        wr(4'h2, 16'h0200);
        wr(4'h0, 16'h80C1);
        chk(sel, 16'h0008);
        chk(dac_code, 16'h0200);
        chk(16'(dac_range), 16'(RANGE_HALF_SUPPLY));
        chk(pwr, 1);
        chk(neg_sel, 1);
        chk(int_ref, 16'h0000);
        rd(4'h8, 16'h0000);
        pin_level[3] <= 10'h300;
        repeat (5) @(posedge clk);
        pin_level[3] <= 10'h000;
        repeat (30) @(posedge clk);
        chk(trig_n, 0);
        pin_level[3] <= 10'h300;
        for (int i = 0; i <= 60; i++) begin
            @(posedge clk);
            #1 if (trig === 1'b1) break;
        end
        if (trig !== 1'b1) bad_count++;
        repeat (2) @(posedge clk);
        #1 chk({result, duty, period, fault, irq}, 16'h001F);
        chk(trig_n, 1);
        rd(4'h4, 16'h0001);
        rd(4'h0, 16'h80C9);
        wr(4'h4, 16'h0001);
        chk(irq, 0);
        wr(4'h0, 16'h80C3);
        repeat (25) @(posedge clk);
        #1 chk(result, 0);
        @(posedge clk);
        fault_clear <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(fault, 0);
        @(posedge clk);
        power_mode <= POWER_SLEEP;
        pin_level[3] <= 10'h000;
        repeat (2) @(posedge clk);
        #1 chk({wake, irq}, 16'h0003);
        @(posedge clk);
        power_mode <= POWER_IDLE;
        wr(4'h0, 16'hA0E3);
        chk(pwr, 0);
        chk(16'(dac_range), 16'(RANGE_EXTERNAL));
        chk(ext_ref, 1);
        chk(halt_out, 16'h0001);
        @(posedge clk);
        group_halt <= 1'b1;
        wr(4'h0, 16'h80C3);
        chk(pwr, 0);
        tally_and_finish;
    end
endmodule
